// *** elss_pkg.sv ***
//----------------------------------------------------------------------------
// Purpose : constants and decode helpers for the upper line source select
// Assumes : one 32-bit register on a byte-addressed Avalon-MM slave
// Notes   : field order in the register is line12 (low) to line15 (high)
//----------------------------------------------------------------------------
package elss_pkg;

    //------------------------------------------------------------------------
    // bus and register layout
    //------------------------------------------------------------------------
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  REG_OFFSET  = 8'h10;
    localparam logic [31:0] REG_RESET   = 32'h00000000;
    localparam logic [31:0] WRITE_MASK  = 32'h3F3F3F3F;
    localparam int          SEL_W       = 6;
    localparam int          LINE_COUNT  = 4;
    localparam int          LINE12_LSB  = 0;
    localparam int          LINE13_LSB  = 8;
    localparam int          LINE14_LSB  = 16;
    localparam int          LINE15_LSB  = 24;

    //------------------------------------------------------------------------
    // selection code encoding: pin index high, port low
    //------------------------------------------------------------------------
    localparam logic [1:0]  PORT_A      = 2'h0;
    localparam logic [1:0]  PORT_B      = 2'h1;
    localparam logic [1:0]  PORT_C      = 2'h2;
    localparam logic [1:0]  PORT_D      = 2'h3;
    localparam logic [3:0]  C_FIRST_PIN = 4'hD;
    localparam logic [3:0]  D_FIRST_PIN = 4'hC;
    localparam logic [3:0]  D_LONE_PIN  = 4'h0;

    // true when the code names a pin that exists for the line
    function automatic logic elss_code_ok(input logic [5:0] code);
        logic [3:0] idx;
        idx = code[5:2];
        case (code[1:0])
            PORT_A:  elss_code_ok = 1'b1;
            PORT_B:  elss_code_ok = 1'b1;
            PORT_C:  elss_code_ok = (idx >= C_FIRST_PIN);
            default: elss_code_ok = (idx == D_LONE_PIN) ||
                                    (idx >= D_FIRST_PIN);
        endcase
    endfunction : elss_code_ok

    // level picked by a code; unsupported codes give a constant zero
    function automatic logic elss_pick(input logic [5:0]  code,
                                       input logic [15:0] pa,
                                       input logic [15:0] pb,
                                       input logic [15:0] pc,
                                       input logic [15:0] pd);
        logic [3:0] idx;
        idx = code[5:2];
        if (!elss_code_ok(code)) begin
            elss_pick = 1'b0;
        end else begin
            case (code[1:0])
                PORT_A:  elss_pick = pa[idx];
                PORT_B:  elss_pick = pb[idx];
                PORT_C:  elss_pick = pc[idx];
                default: elss_pick = pd[idx];
            endcase
        end
    endfunction : elss_pick

endpackage : elss_pkg

// *** elss_line_mux.sv ***
//----------------------------------------------------------------------------
// Purpose : one line source multiplexer with a registered output
// Assumes : pin buses are already synchronised to ref_clk
// Notes   : output follows the code and pins one clock later
//----------------------------------------------------------------------------
`timescale 1ns/1ps
module elss_line_mux (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [5:0]  code,
    input  wire logic [15:0] pa,
    input  wire logic [15:0] pb,
    input  wire logic [15:0] pc,
    input  wire logic [15:0] pd,
    output logic             line_out
);
    import elss_pkg::*;

    //------------------------------------------------------------------------
    // selection register
    //------------------------------------------------------------------------
    // decode pin and port
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            line_out <= 1'b0;
        end else begin
            line_out <= elss_pick(code, pa, pb, pc, pd);
        end
    end

endmodule : elss_line_mux

// *** elss_upper_line_select.sv ***
//----------------------------------------------------------------------------
// Purpose : upper line pin select register of the alternate_function_unit
// Assumes : Avalon-MM slave, byte addresses, one register word at 0x10
// Notes   : selected pin levels feed edge detection outside this block
//----------------------------------------------------------------------------
// Notes on behaviour
// - line15_source_sel is a writable 6-bit field in bits 29 to 24.
// - line14_source_sel is a writable 6-bit field in bits 21 to 16.
// - code high four bits give pin index, low two give port A to D.
// - A and B any pin; D pins 0,12-15; C pins 13-15; else zero.
// - after reset the register reads all zeros, every line on pin A0.
// - line13_source_sel is a writable 6-bit field in bits 13 to 8.
//----------------------------------------------------------------------------
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
module elss_upper_line_select (
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    input  wire logic [elss_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [31:0]                 avs_writedata,
    input  wire logic [3:0]                  avs_byteenable,
    output logic      [31:0]                 avs_readdata,
    output logic                             avs_waitrequest,
    input  wire logic [15:0]                 port_a_pins,
    input  wire logic [15:0]                 port_b_pins,
    input  wire logic [15:0]                 port_c_pins,
    input  wire logic [15:0]                 port_d_pins,
    output logic                             line12_signal,
    output logic                             line13_signal,
    output logic                             line14_signal,
    output logic                             line15_signal
);
    import elss_pkg::*;

    logic [31:0]      cfg;          // select register, reserved bits zero
    logic [3:0][15:0] pin_meta;     // first synchroniser stage
    logic [3:0][15:0] pin_sync;     // second synchroniser stage
    logic [3:0][5:0]  line_code;    // per-line selection code
    logic [3:0]       line_bits;    // registered line levels
    logic [3:0]       expect_bits;  // reference levels for checking
    logic             bus_req;
    logic             reg_hit;
    logic             write_ack;

    //------------------------------------------------------------------------
    // bus decode
    //------------------------------------------------------------------------
    // request, address match and write acceptance
    assign bus_req   = avs_read | avs_write;
    assign reg_hit   = (avs_address == REG_OFFSET);
    assign write_ack = avs_write & ~avs_waitrequest & reg_hit;

    //------------------------------------------------------------------------
    // wait state: one waited cycle, then one ready cycle per request
    //------------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else if (bus_req && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // read data captured with the wait drop; unmapped reads return zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= reg_hit ? cfg : 32'h00000000;
        end
    end

    //------------------------------------------------------------------------
    // select register
    //------------------------------------------------------------------------
    // clear on reset
    // byte-lane field writes, reserved bits forced to zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg <= REG_RESET;
        end else if (write_ack) begin
            for (int i = 0; i < 4; i++) begin
                if (avs_byteenable[i]) begin
                    cfg[i*8 +: 8] <= avs_writedata[i*8 +: 8] &
                                     WRITE_MASK[i*8 +: 8];
                end
            end
        end
    end

    // fields in line order, line12 first
    assign line_code[0] = cfg[LINE12_LSB +: SEL_W];
    assign line_code[1] = cfg[LINE13_LSB +: SEL_W];
    assign line_code[2] = cfg[LINE14_LSB +: SEL_W];
    assign line_code[3] = cfg[LINE15_LSB +: SEL_W];

    //------------------------------------------------------------------------
    // pin synchronisers
    //------------------------------------------------------------------------
    // two stages, only the second stage is read by logic
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {port_d_pins, port_c_pins, port_b_pins, port_a_pins};
            pin_sync <= pin_meta;
        end
    end

    //------------------------------------------------------------------------
    // line multiplexers
    //------------------------------------------------------------------------
    // per-line pin selection
    for (genvar g = 0; g < LINE_COUNT; g++) begin : g_line
        elss_line_mux u_mux (
            .ref_clk  (ref_clk),
            .rst      (rst),
            .code     (line_code[g]),
            .pa       (pin_sync[0]),
            .pb       (pin_sync[1]),
            .pc       (pin_sync[2]),
            .pd       (pin_sync[3]),
            .line_out (line_bits[g])
        );
    end

    // outputs taken straight from the multiplexer flops
    assign line12_signal = line_bits[0];
    assign line13_signal = line_bits[1];
    assign line14_signal = line_bits[2];
    assign line15_signal = line_bits[3];

    //------------------------------------------------------------------------
    // checks
    //------------------------------------------------------------------------
    // reference levels from the current code and synchronised pins
    always_comb begin
        for (int i = 0; i < LINE_COUNT; i++) begin
            // pin indexed directly, gated by code validity, not the mux path
            expect_bits[i] = pin_sync[line_code[i][1:0]][line_code[i][5:2]]
                             & elss_code_ok(line_code[i]);
        end
    end

    line15_field_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (write_ack && avs_byteenable[3]) |=>
            (cfg[LINE15_LSB +: SEL_W] ==
             $past(avs_writedata[LINE15_LSB +: SEL_W])))
        else $error("line15 select field did not take the write");

    line14_field_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (write_ack && avs_byteenable[2]) |=>
            (cfg[LINE14_LSB +: SEL_W] ==
             $past(avs_writedata[LINE14_LSB +: SEL_W])))
        else $error("line14 select field did not take the write");

    line13_field_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (write_ack && avs_byteenable[1]) |=>
            (cfg[LINE13_LSB +: SEL_W] ==
             $past(avs_writedata[LINE13_LSB +: SEL_W])))
        else $error("line13 select field did not take the write");

    line12_field_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (write_ack && avs_byteenable[0]) |=>
            (cfg[LINE12_LSB +: SEL_W] ==
             $past(avs_writedata[LINE12_LSB +: SEL_W])))
        else $error("line12 select field did not take the write");

    line_decode_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        ##1 (line_bits == $past(expect_bits)))
        else $error("line level does not match the selected pin");

    bad_code_zero_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (!elss_code_ok(line_code[2]) || !elss_code_ok(line_code[3])) |=>
            ((!$past(elss_code_ok(line_code[2])) -> !line14_signal) &&
             (!$past(elss_code_ok(line_code[3])) -> !line15_signal)))
        else $error("unsupported code did not give a zero level");

    reset_clear_a: assert property (
        @(posedge ref_clk)
        $fell(rst) |-> (cfg == REG_RESET) && (line_bits == 4'h0))
        else $error("select register not clear after reset");

    reserved_zero_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        ((avs_readdata & ~WRITE_MASK) == 32'h00000000) &&
        ((cfg & ~WRITE_MASK) == 32'h00000000))
        else $error("reserved bits are not zero");

    // one ready cycle, then wait again
    bus_ready_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        bus_req |-> ##[0:1] !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest did not answer in one cycle");

endmodule : elss_upper_line_select

// *** tb_elss_upper_line_select.sv ***
//----------------------------------------------------------------------------
// Purpose : self-checking bench for the upper line pin select register
// Assumes : Avalon-MM slave answers after one wait cycle, lines lag pins 3
// Notes   : pins are driven one-hot and inverse-one-hot for every code
//----------------------------------------------------------------------------
`timescale 1ns/1ps
module tb_elss_upper_line_select;
    import elss_pkg::*;

    `define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
        n_mismatch++; $display("wrong value at %0t: got %h expected %h", \
        $time, (got), (exp)); end end

    //------------------------------------------------------------------------
    // signals
    //------------------------------------------------------------------------
    logic                ref_clk;
    logic                rst;
    logic [ADDR_W-1:0]   avs_address;
    logic                avs_read;
    logic                avs_write;
    logic [31:0]         avs_writedata;
    logic [3:0]          avs_byteenable;
    logic [31:0]         avs_readdata;
    logic                avs_waitrequest;
    logic [15:0]         pa;
    logic [15:0]         pb;
    logic [15:0]         pc;
    logic [15:0]         pd;
    logic                l12;
    logic                l13;
    logic                l14;
    logic                l15;
    logic [31:0]         rd;
    logic [5:0]          c;
    int                  n_mismatch;
    int                  tests_run;

    // clock of 10 ns
    always #5 ref_clk = ~ref_clk;

    elss_upper_line_select DUT (
        .ref_clk         (ref_clk),
        .rst             (rst),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .port_a_pins     (pa),
        .port_b_pins     (pb),
        .port_c_pins     (pc),
        .port_d_pins     (pd),
        .line12_signal   (l12),
        .line13_signal   (l13),
        .line14_signal   (l14),
        .line15_signal   (l15)
    );

    //------------------------------------------------------------------------
    // tasks
    //------------------------------------------------------------------------
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up

    // hold the request until waitrequest is sampled low
    task automatic wait_ack;
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        // an answer on the last try is still an answer
        if (avs_waitrequest !== 1'b0) begin
            n_mismatch++;
            wrap_up();
        end
    endtask : wait_ack

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d,
                             input logic [3:0] be);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_write      <= 1'b1;
        wait_ack();
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask : bus_write

    task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
        avs_address <= a;
        avs_read    <= 1'b1;
        wait_ack();
        d = avs_readdata;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask : bus_read

    // let pins pass two sync flops and the mux flop, then compare lines
    task automatic chk_lines(input logic [3:0] exp);
        repeat (3) @(posedge ref_clk);
        #1;
        `CHK({l15, l14, l13, l12}, exp)
        @(posedge ref_clk);
    endtask : chk_lines

    // drive the pin named by a code alone high, or alone low when inv
    task automatic put_pins(input logic [5:0] k, input logic inv);
        logic [15:0] s;
        s  = 16'h0001 << k[5:2];
        pa <= ((k[1:0] == 2'h0) ? s : 16'h0000) ^ {16{inv}};
        pb <= ((k[1:0] == 2'h1) ? s : 16'h0000) ^ {16{inv}};
        pc <= ((k[1:0] == 2'h2) ? s : 16'h0000) ^ {16{inv}};
        pd <= ((k[1:0] == 2'h3) ? s : 16'h0000) ^ {16{inv}};
    endtask : put_pins

    // codes that name an existing pin
    function automatic logic code_valid(input logic [5:0] k);
        case (k[1:0])
            2'h0, 2'h1: return 1'b1;
            2'h2:       return k[5:2] >= 4'hD;
            default:    return (k[5:2] == 4'h0) || (k[5:2] >= 4'hC);
        endcase
    endfunction : code_valid

    //------------------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------------------
    initial begin
        ref_clk = 1'b0; rst = 1'b1; avs_address = 8'h00; avs_read = 1'b0;
        avs_write = 1'b0; avs_writedata = 32'h0; avs_byteenable = 4'h0;
        pa = 16'h0; pb = 16'h0; pc = 16'h0; pd = 16'h0;
        n_mismatch = 0; tests_run = 0;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        // reset value and pin A0 on every line
        bus_read(REG_OFFSET, rd);
        `CHK(rd, 32'h00000000)
        pa <= 16'h0001;
        chk_lines(4'hF);
        // reserved pairs written as zero, all fields writable
        bus_write(REG_OFFSET, 32'h3F3F3F3F, 4'hF);
        bus_read(REG_OFFSET, rd);
        `CHK(rd, 32'h3F3F3F3F)
        bus_write(REG_OFFSET, 32'h00000000, 4'h8);
        bus_read(REG_OFFSET, rd);
        `CHK(rd, 32'h003F3F3F)
        // unmapped place: write ignored, read zero
        bus_write(8'h14, 32'h00000000, 4'hF);
        bus_read(REG_OFFSET, rd);
        `CHK(rd, 32'h003F3F3F)
        bus_read(8'h14, rd);
        `CHK(rd, 32'h00000000)
        // each field drives its own line
        for (int k = 0; k < 4; k++) begin
            bus_write(REG_OFFSET, 32'h00000003 << (8 * k), 4'hF);
            put_pins(6'h03, 1'b0);
            chk_lines(4'h1 << k);
        end
        // every code on all four lines
        for (int i = 0; i < 64; i++) begin
            c = i[5:0];
            bus_write(REG_OFFSET, {4{2'b00, c}}, 4'hF);
            bus_read(REG_OFFSET, rd);
            `CHK(rd, {4{2'b00, c}})
            put_pins(c, 1'b0);
            chk_lines({4{code_valid(c)}});
            put_pins(c, 1'b1);
            chk_lines(4'h0);
        end
        wrap_up();
    end

endmodule : tb_elss_upper_line_select
